// [rtl/iad_top.sv]
/*
 Command and result registers with conversion-start control of a serial
 multi-slope integrating ADC. The analog front end supplies the measured and
 offset values on the system clock; the host reaches the registers over the
 four-wire serial link on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module iad_top (
   input  wire logic        sys_clk,      // Conversion clock, 200 MHz
   input  wire logic        reset,        // Synchronous reset, high
   input  wire logic        link_clk,     // Serial clock from host
   input  wire logic        csN,          // Chip select, low in frame
   input  wire logic        din,          // Serial data in
   input  wire logic [18:0] measValue,    // Input plus offset count, twos complement
   input  wire logic [18:0] zeroValue,    // Offset count, twos complement
   output logic             sdo,          // Serial data out
   output logic             eocOut,       // End of conversion line
   output logic             integrating,  // Integrate phase active
   output logic             shortInputs,  // Inputs shorted for zero reading
   output logic             oscStop,      // Oscillator stopped, asleep
   output logic [3:0]       userOut       // user_out_first..user_out_fourth
);
   // ****************************************************************
   // Link and crossing
   // ****************************************************************
   logic [7:0] rxByte;
   logic [7:0] txByte_r;
   logic [7:0] txByte_nxt;
   logic       csSync;
   logic       csPrev_r;
   logic       csRise;

   iad_link u_link (
      .link_clk (link_clk),
      .csN      (csN),
      .din      (din),
      .txByte   (txByte_r),
      .rxByte   (rxByte),
      .sdo      (sdo)
   );

   iad_sync #(.WIDTH(1)) u_cs_sync (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in (csN),
      .sync_out (csSync)
   );

   // Byte is still since the serial clock stops once chip select is high
   assign csRise = csSync & ~csPrev_r;

   // ****************************************************************
   // Command registers
   // ****************************************************************
   iad_pkg::iad_cmd0_s cmd0_r;
   iad_pkg::iad_cmd0_s cmd0_nxt;
   logic [3:0]         user_nxt;
   logic               writeCmd0;
   logic               writeUser;
   iad_pkg::iad_cmd0_s cmdIn;

   // ****************************************************************
   // Sequencing state
   // ****************************************************************
   logic [10:0]        cnt_r;
   logic [10:0]        cnt_nxt;
   logic [2:0]         clrCnt_r;
   logic [2:0]         clrCnt_nxt;
   logic               accept;
   logic               eoc_nxt;
   logic               asleep_nxt;
   logic               zeroRun_nxt;
   logic               rate50Run_r;
   logic               rate50Run_nxt;
   logic               integ_nxt;
   logic [10:0]        intBegin;
   logic [10:0]        intEnd;
   logic               lastCount;

   // ****************************************************************
   // Result and status state
   // ****************************************************************
   logic [18:0]        result_r;
   logic [18:0]        result_nxt;
   logic [18:0]        newResult;
   logic               collision_r;
   logic               collision_nxt;
   logic               latchInFrame_r;
   logic               latchInFrame_nxt;
   iad_pkg::iad_status_s status;
   iad_pkg::iad_sel_e  sel;

   assign writeCmd0 = csRise & ~rxByte[iad_pkg::DEST_BIT];
   assign writeUser = csRise &  rxByte[iad_pkg::DEST_BIT];
   assign accept    = ~oscStop & (cnt_r == iad_pkg::CNT_ZERO) & cmd0_r.start;
   assign lastCount = ~oscStop & (cnt_r == iad_pkg::CNT_LAST);
   assign sel       = iad_pkg::iad_sel_e'({cmd0_r.outputSelectHigh, cmd0_r.outputSelectLow});
   assign cmdIn     = iad_pkg::iad_cmd0_s'(rxByte);

   always_comb begin
      cmd0_nxt = cmd0_r;
      user_nxt = userOut;
      if (writeUser) begin
         user_nxt = rxByte[iad_pkg::USER_LSB +: 4];
      end
      // Set by the host wins over the self clear in the same cycle
      if (~oscStop && clrCnt_r == iad_pkg::CLR_LAST) begin
         cmd0_nxt.start = 1'b0;
      end
      if (writeCmd0) begin
         cmd0_nxt = cmdIn;
      end
   end

   // ****************************************************************
   // Conversion counter, start control, sleep
   // ****************************************************************
   always_comb begin
      cnt_nxt       = cnt_r;
      clrCnt_nxt    = clrCnt_r;
      zeroRun_nxt   = shortInputs;
      rate50Run_nxt = rate50Run_r;
      asleep_nxt    = oscStop;
      if (!oscStop) begin
         if (cnt_r == iad_pkg::CNT_ZERO) begin
            if (cmd0_r.start) begin
               cnt_nxt       = iad_pkg::CNT_ONE;
               clrCnt_nxt    = iad_pkg::START_CLR_CYC;
               zeroRun_nxt   = cmd0_r.readZero;
               rate50Run_nxt = cmd0_r.rate50;
            end
         end else begin
            // Wraps to zero and halts there until a start is pending
            cnt_nxt = cnt_r + iad_pkg::CNT_ONE;
         end
         if (clrCnt_r != 3'h0) begin
            clrCnt_nxt = clrCnt_r - 3'h1;
         end
      end
      eoc_nxt = (cnt_nxt == iad_pkg::CNT_ZERO);
      if (eoc_nxt && !eocOut && cmd0_r.sleep) begin
         asleep_nxt = 1'b1;
      end
      if (writeCmd0 && !cmdIn.sleep) begin
         asleep_nxt = 1'b0;
      end
      intBegin  = rate50Run_nxt ? iad_pkg::ZERO_INT_50 : iad_pkg::ZERO_INT_60;
      intEnd    = intBegin + (rate50Run_nxt ? iad_pkg::INT_LEN_50 : iad_pkg::INT_LEN_60);
      integ_nxt = (cnt_nxt >= intBegin) && (cnt_nxt < intEnd);
   end

   // ****************************************************************
   // Result latch, collision, read mux
   // ****************************************************************
   always_comb begin
      newResult = shortInputs ? zeroValue : measValue;
      result_nxt       = lastCount ? newResult : result_r;
      latchInFrame_nxt = latchInFrame_r;
      collision_nxt    = collision_r;
      if (lastCount && !csSync) begin
         latchInFrame_nxt = 1'b1;
      end
      if (csRise) begin
         if (sel == iad_pkg::IAD_SEL_STATUS) begin
            collision_nxt = 1'b0;
         end
         if (latchInFrame_r) begin
            collision_nxt    = 1'b1;
            latchInFrame_nxt = 1'b0;
         end
      end
      status.collision   = collision_r;
      status.eoc         = eocOut;
      status.integrating = integrating;
      status.asleep      = oscStop;
      status.negative    = result_r[iad_pkg::SIGN_BIT];
      status.lowBits     = result_r[iad_pkg::LOW_LSB-1:0];
      if (sel == iad_pkg::IAD_SEL_LOW) begin
         txByte_nxt = result_r[iad_pkg::LOW_LSB +: 8];
      end else if (sel == iad_pkg::IAD_SEL_HIGH) begin
         txByte_nxt = result_r[iad_pkg::HIGH_LSB +: 8];
      end else if (sel == iad_pkg::IAD_SEL_STATUS) begin
         txByte_nxt = status;
      end else begin
         txByte_nxt = iad_pkg::UNDEF_BYTE;
      end
      // Hold the byte through a frame so the link side never sees it move
      if (!csSync) begin
         txByte_nxt = txByte_r;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         csPrev_r       <= 1'b1;
         cmd0_r         <= iad_pkg::iad_cmd0_s'(iad_pkg::CMD0_RESET);
         userOut        <= iad_pkg::USER_RESET;
         cnt_r          <= iad_pkg::CNT_ZERO;
         clrCnt_r       <= 3'h0;
         eocOut         <= 1'b1;
         oscStop        <= 1'b0;
         shortInputs    <= 1'b0;
         rate50Run_r    <= 1'b0;
         integrating    <= 1'b0;
         result_r       <= '0;
         collision_r    <= 1'b0;
         latchInFrame_r <= 1'b0;
         txByte_r       <= 8'h00;
      end else begin
         csPrev_r       <= csSync;
         cmd0_r         <= cmd0_nxt;
         userOut        <= user_nxt;
         cnt_r          <= cnt_nxt;
         clrCnt_r       <= clrCnt_nxt;
         eocOut         <= eoc_nxt;
         oscStop        <= asleep_nxt;
         shortInputs    <= zeroRun_nxt;
         rate50Run_r    <= rate50Run_nxt;
         integrating    <= integ_nxt;
         result_r       <= result_nxt;
         collision_r    <= collision_nxt;
         latchInFrame_r <= latchInFrame_nxt;
         txByte_r       <= txByte_nxt;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_accept;
      accept && !csRise;
   endsequence

   sequence s_quietRun;
      s_accept ##1 (!csRise && !oscStop) [*5];
   endsequence

   AST_CMD0_LOAD: assert property (writeCmd0 |=> cmd0_r == $past(rxByte))
      else $error("conversion command not loaded at chip select rise");
   AST_USER_LOAD: assert property (writeUser |=> userOut == $past(rxByte[7:4]))
      else $error("user outputs not loaded");
   AST_USER_HOLD: assert property (!writeUser |=> $stable(userOut))
      else $error("user outputs changed without a write");
   AST_START_ACCEPT: assert property (s_accept |=> cnt_r == iad_pkg::CNT_ONE)
      else $error("accepted start did not move count to one");
   AST_START_CLEAR: assert property (s_quietRun |=> !cmd0_r.start)
      else $error("start bit not cleared five cycles after acceptance");
   AST_IDLE_HOLD: assert property (cnt_r == iad_pkg::CNT_ZERO && !cmd0_r.start
                                   |=> cnt_r == iad_pkg::CNT_ZERO)
      else $error("counter left zero without a start");
   AST_EOC_AT_ZERO: assert property (eocOut == (cnt_r == iad_pkg::CNT_ZERO))
      else $error("end of conversion does not match count zero");
   AST_SLEEP_ENTRY: assert property ($rose(eocOut) && $past(cmd0_r.sleep) && !$past(writeCmd0)
                                     |-> oscStop)
      else $error("sleep not entered at end of conversion");
   AST_FREEZE: assert property (oscStop && $past(oscStop) |-> $stable(cnt_r))
      else $error("counter moved while asleep");
   AST_RESULT: assert property (lastCount |=> result_r == $past(newResult) && eocOut)
      else $error("result not latched at conversion end");

   // ****************************************************************
   // Link, status and crossing checks
   // ****************************************************************
   sequence s_wakeWrite;
      writeCmd0 && !cmdIn.sleep;
   endsequence

   sequence s_latchInFrame;
      lastCount && !csSync;
   endsequence

   AST_WAKE: assert property (s_wakeWrite |=> !oscStop)
      else $error("sleep not left after a wake write");
   AST_SLEEP_KEEP: assert property (oscStop && !writeCmd0 |=> oscStop)
      else $error("sleep left without a command write");
   AST_LATCH_MARK: assert property (s_latchInFrame |=> latchInFrame_r)
      else $error("result latch inside a frame not noted");
   AST_COLLISION_SET: assert property (csRise && latchInFrame_r |=> collision_r)
      else $error("collision not flagged at chip select rise");
   AST_COLLISION_CLEAR: assert property (csRise && sel == iad_pkg::IAD_SEL_STATUS
      && !latchInFrame_r |=> !collision_r)
      else $error("collision not cleared by a status read");
   AST_TX_FROZEN: assert property (!csSync |=> $stable(txByte_r))
      else $error("send byte changed inside a frame");
   AST_LOW_SEL: assert property (csSync && sel == iad_pkg::IAD_SEL_LOW |=>
      txByte_r == $past(result_r[iad_pkg::LOW_LSB +: 8]))
      else $error("low result byte not offered");
   AST_HIGH_SEL: assert property (csSync && sel == iad_pkg::IAD_SEL_HIGH |=>
      txByte_r == $past(result_r[iad_pkg::HIGH_LSB +: 8]))
      else $error("high result byte not offered");
   AST_UNDEF_SEL: assert property (csSync && sel == iad_pkg::IAD_SEL_UNDEF |=>
      txByte_r == iad_pkg::UNDEF_BYTE)
      else $error("undefined select did not offer the fill byte");
   AST_INT_WINDOW: assert property (integrating |-> cnt_r != iad_pkg::CNT_ZERO)
      else $error("integrating while idle at count zero");
   AST_RESULT_HOLD: assert property (!lastCount |=> $stable(result_r))
      else $error("result changed away from conversion end");
   AST_ZERO_RUN: assert property (s_accept |=>
      shortInputs == $past(cmd0_r.readZero))
      else $error("read zero choice not taken at start");
   AST_NO_MID_START: assert property (cnt_r != iad_pkg::CNT_ZERO |=>
      cnt_r != iad_pkg::CNT_ONE)
      else $error("conversion restarted before the count wrapped");
endmodule // iad_top
`default_nettype wire

// [rtl/iad_pkg.sv]
/*
 Constants, field layouts and carrier types for the integrating ADC command
 and result register block. Assumes one system clock for the conversion
 sequencing and a serial clock of the host for the link.
*/
// How it works
// - Command byte bit 0 picks the target: 0 conversion command, 1 user output command.
// - Bit 7 of the conversion command set to 1 requests a conversion start.
// - One conversion per start request, then halt idle until a new request.
// - Start request is sampled only at count zero; acceptance moves count to one.
// - The stored start bit clears itself five cycles after the conversion is accepted.
// - A start written past count five waits and starts when the count wraps to zero.
// - End of conversion bit and line go high when the count reaches zero.
// - Bit 6 picks integrate length: 0 gives 546 counts, 1 gives 655 counts.
// - With the sleep bit set, sleep begins when end of conversion next rises.
// - While asleep the oscillator stops, so counter and sequencing freeze.
// - While asleep the serial link still shifts data out and takes commands.
// - User output command bits 4 to 7 drive user outputs first to fourth.
// - Low result byte holds bits 3 to 10, fresh once end of conversion rises.
// - High result byte holds bits 11 to 18, bit 18 most significant.
// - Result is twos complement; the sign flag reads 1 when negative.
// - Result is the raw sum of offset and input; host subtracts the zero.
// - With read-zero set, the next started conversion measures shorted inputs.
// - Select bits 00 low byte, 01 high byte, 10 status, 11 undefined.
// - Eight-bit full-duplex frames, MSB first; read byte follows previous frame's select.
// - The received byte is loaded into its command register when chip select rises.
package iad_pkg;

   // ****************************************************************
   // Sequencing figures
   // ****************************************************************
   localparam int unsigned CNT_W          = 11;
   localparam int unsigned RES_W          = 19;
   localparam logic [10:0] CNT_ZERO       = 11'h000;
   localparam logic [10:0] CNT_ONE        = 11'h001;
   localparam logic [10:0] CNT_LAST       = 11'h7FF;
   localparam logic [2:0]  START_CLR_CYC  = 3'h5;
   localparam logic [2:0]  CLR_LAST       = 3'h1;
   localparam logic [10:0] INT_LEN_60     = 11'h222;
   localparam logic [10:0] INT_LEN_50     = 11'h28F;
   localparam logic [10:0] ZERO_INT_60    = 11'h06F;
   localparam logic [10:0] ZERO_INT_50    = 11'h001;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned DEST_BIT       = 0;
   localparam int unsigned USER_LSB       = 4;
   localparam int unsigned SIGN_BIT       = 18;
   localparam int unsigned LOW_LSB        = 3;
   localparam int unsigned HIGH_LSB       = 11;
   localparam logic [7:0]  UNDEF_BYTE     = 8'h00;
   localparam logic [7:0]  CMD0_RESET     = 8'h00;
   localparam logic [3:0]  USER_RESET     = 4'h0;

   typedef enum logic [1:0] {
      IAD_SEL_LOW    = 2'b00,
      IAD_SEL_HIGH   = 2'b01,
      IAD_SEL_STATUS = 2'b10,
      IAD_SEL_UNDEF  = 2'b11
   } iad_sel_e;

   typedef struct packed {
      logic start;
      logic rate50;
      logic sleep;
      logic readZero;
      logic spare;
      logic outputSelectLow;
      logic outputSelectHigh;
      logic dest;
   } iad_cmd0_s;

   typedef struct packed {
      logic       collision;
      logic       eoc;
      logic       integrating;
      logic       asleep;
      logic       negative;
      logic [2:0] lowBits;
   } iad_status_s;

endpackage

// [rtl/iad_sync.sv]
/*
 Two flip-flop level synchroniser for signals entering the system clock.
 Assumes the input changes slowly compared with the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module iad_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             sys_clk,   // System clock
   input  wire logic             reset,     // Synchronous reset, high
   input  wire logic [WIDTH-1:0] async_in,  // Level from another domain
   output logic      [WIDTH-1:0] sync_out   // Synchronised level
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_r   <= '1;
         sync_out <= '1;
      end else begin
         meta_r   <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end
endmodule // iad_sync
`default_nettype wire

// [rtl/iad_link.sv]
/*
 Serial link shifter on the host's serial clock. Receives MSB first on rising
 edges and sends MSB first on falling edges. Assumes the serial clock idles
 high, so the first edge of a frame is falling, and chip select is high
 between frames, which clears the bit counter.
*/
`timescale 1ns/1ps
`default_nettype none
module iad_link (
   input  wire logic       link_clk,  // Serial clock from host
   input  wire logic       csN,       // Chip select, low in frame
   input  wire logic       din,       // Serial data in
   input  wire logic [7:0] txByte,    // Byte to send, stable in frame
   output logic      [7:0] rxByte,    // Last received byte
   output logic            sdo        // Serial data out
);
   logic [2:0] bitCnt_r;
   logic [2:0] bitCnt_nxt;
   logic       sdo_nxt;
   logic [7:0] rx_nxt;

   always_comb begin
      rx_nxt     = {rxByte[6:0], din};
      sdo_nxt    = txByte[3'h7 - bitCnt_r];
      bitCnt_nxt = bitCnt_r + 3'h1;
   end

   always_ff @(posedge link_clk) begin
      rxByte <= rx_nxt;
   end

   // Chip select high parks the sender ready for a fresh frame
   always_ff @(negedge link_clk or posedge csN) begin
      if (csN) begin
         bitCnt_r <= 3'h0;
         sdo      <= 1'b0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         sdo      <= sdo_nxt;
      end
   end
endmodule // iad_link
`default_nettype wire

// [tb/iad_host_model.sv]
/*
 Host side of the four-wire serial link: a behavioural master that frames
 one byte each call. Assumes the device loads the byte within a few system
 clocks after chip select rises.
*/
`timescale 1ns/1ps
`default_nettype none
module iad_host_model (
   output logic      link_clk,  // Serial clock, idles high
   output logic      csN,       // Chip select, low in frame
   output logic      din,       // Serial data to device
   input  wire logic sdo        // Serial data from device
);
   // ****************************************************************
   // Idle levels
   // ****************************************************************
   initial begin
      link_clk = 1'b1;
      csN      = 1'b1;
      din      = 1'b0;
   end

   // ****************************************************************
   // One frame, 32 ns serial period; leadNs stretches the setup
   // ****************************************************************
   task automatic xfer(input logic [7:0] txb, input int leadNs, output logic [7:0] rxb);
      int i;
      begin
         // Offset keeps the serial edges clear of the system clock edges
         #0.7;
         csN = 1'b0;
         #(leadNs);
         for (i = 7; i >= 0; i--) begin
            link_clk = 1'b0;
            din      = txb[i];
            #16;
            link_clk = 1'b1;
            rxb[i]   = sdo;
            #16;
         end
         #10;
         csN = 1'b1;
         din = ~din;
         #60;
      end
   endtask
endmodule // iad_host_model
`default_nettype wire

// [tb/tb_iad_top.sv]
/*
 Self-checking bench for the command and result register block. Assumes
 the host model frames every byte and the front end values are static
 during each conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_iad_top;
   logic        sys_clk;        // System clock
   logic        reset;          // Synchronous reset
   logic        link_clk;       // Serial clock
   logic        csN;            // Chip select
   logic        din;            // Serial data in
   logic [18:0] measValue;      // Measured value
   logic [18:0] zeroValue;      // Offset value
   logic        sdo;            // Serial data out
   logic        eocOut;         // End of conversion
   logic        integrating;    // Integrate phase
   logic        shortInputs;    // Zero reading
   logic        oscStop;        // Asleep
   logic [3:0]  userOut;        // User outputs
   logic [7:0]  rx;             // Byte read back
   int          miscompares;    // Mismatch count
   int          samplesChecked; // Compare count
   int          cycles;         // Timeout counter

   iad_top u_iad_top (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .csN(csN),
      .din(din), .measValue(measValue), .zeroValue(zeroValue), .sdo(sdo), .eocOut(eocOut),
      .integrating(integrating), .shortInputs(shortInputs), .oscStop(oscStop),
      .userOut(userOut));
   iad_host_model u_iad_host_model (.link_clk(link_clk), .csN(csN), .din(din), .sdo(sdo));

   // ****************************************************************
   // Clock, timeout, reporting
   // ****************************************************************
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic frame(input logic [7:0] cmd);
      u_iad_host_model.xfer(cmd, 10, rx);
   endtask

   // Waits for a conversion; counts its length and integrate cycles
   task automatic runConv(output int len, output int intCyc, output logic shortSeen);
      int i;
      begin
         i = 0;
         len = 0;
         intCyc = 0;
         shortSeen = 1'b0;
         while (eocOut !== 1'b0 && i < 200) begin
            @(posedge sys_clk);
            #1;
            i++;
         end
         while (eocOut !== 1'b1 && len < 3000) begin
            if (integrating === 1'b1) intCyc++;
            if (shortInputs === 1'b1) shortSeen = 1'b1;
            @(posedge sys_clk);
            #1;
            len++;
         end
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_user();
      check("eoc after reset", eocOut, 1'b1);
      frame(8'hA1);
      check("user outputs", userOut, 4'hA);
      frame(8'h00);
      check("user outputs kept", userOut, 4'hA);
      frame(8'h51);
      check("user outputs rewritten", userOut, 4'h5);
   endtask

   task automatic test_conv(input logic [7:0] cmd, input int expInt, input logic expShort);
      int len;
      int intCyc;
      logic shortSeen;
      begin
         // Watch from the start edge while the command is still being sent
         fork
            frame(cmd);
            runConv(len, intCyc, shortSeen);
         join
         check("conversion length", 19'(len), 19'd2047);
         check("integrate cycles", 19'(intCyc), 19'(expInt));
         check("inputs shorted", shortSeen, expShort);
         repeat (30) @(posedge sys_clk);
         #1;
         check("single conversion", eocOut, 1'b1);
      end
   endtask

   task automatic test_readback(input logic [18:0] exp);
      frame(8'h04);
      frame(8'h02);
      check("high byte", rx, exp[18:11]);
      frame(8'h06);
      check("status byte", rx, {3'b010, 1'b0, exp[18], exp[2:0]});
      frame(8'h00);
      check("undefined select", rx, 8'h00);
      frame(8'h00);
      check("low byte", rx, exp[10:3]);
   endtask

   task automatic test_back2back();
      int len;
      int intCyc;
      logic shortSeen;
      begin
         frame(8'h80);
         repeat (200) @(posedge sys_clk);
         frame(8'h80);
         runConv(len, intCyc, shortSeen);
         @(posedge sys_clk);
         #1;
         check("pending start taken at wrap", eocOut, 1'b0);
         runConv(len, intCyc, shortSeen);
         check("second length", 19'(len), 19'd2047);
         repeat (30) @(posedge sys_clk);
         #1;
         check("start cleared", eocOut, 1'b1);
      end
   endtask

   task automatic test_sleep();
      int len;
      int intCyc;
      logic shortSeen;
      begin
         frame(8'hA0);
         runConv(len, intCyc, shortSeen);
         repeat (3) @(posedge sys_clk);
         #1;
         check("asleep", oscStop, 1'b1);
         frame(8'hA2);
         repeat (20) @(posedge sys_clk);
         #1;
         check("frozen while asleep", eocOut, 1'b1);
         frame(8'h20);
         check("status asleep", rx[4:3], 2'b10);
         frame(8'h00);
         check("awake", oscStop, 1'b0);
         repeat (2100) @(posedge sys_clk);
         #1;
         check("no start from sleep write", eocOut, 1'b1);
      end
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      reset = 1'b1;
      measValue = 19'h5A3C7;
      zeroValue = 19'h0012D;
      miscompares = 0;
      samplesChecked = 0;
      cycles = 0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      test_user();
      test_conv(8'h80, 546, 1'b0);
      test_readback(19'h5A3C7);
      @(posedge sys_clk);
      measValue <= 19'h23456;
      test_conv(8'hD0, 655, 1'b1);
      test_readback(19'h0012D);
      test_back2back();
      test_sleep();
      conclude();
   end
endmodule // tb_iad_top
`default_nettype wire
